// ==== verilog/sfe_flash_cmds.sv ====
// How it works
// - 52H plus three address bytes erases 32KB
// - D8H plus three address bytes erases 64KB
// - Low in-block address bits are ignored
// - Deselect only after bit 32, else drop
// - Erase needs the write enable latch set
// - Busy flag high during self-timed erase
// - Latch cleared before finish; status stays readable
// - Protected block erase is not executed
// - 60H or C7H alone is chip erase
// - Chip erase deselect only after bit 8
// - Chip erase only with matching protect setting
// - 90H, address, then maker and device bytes
// - Output changes on falling clock, MSB first
// - 9FH returns maker, type, capacity bytes
// - 9FH ignored while a cycle runs
// - Deselect ends any identification read
// - 4BH, address, dummy, then 128-bit number
// - 44H erases one of two security registers
// - Security erase deselect after bit 32, self-timed
// - Any lock bit set ignores security erase
// - Input bits sampled on rising serial clock
`default_nettype none
module sfe_flash_cmds
  import sfe_pkg::*;
#(
  parameter int             BE32_TIME_US = 150,
  parameter int             BE64_TIME_US = 250,
  parameter int             CHIP_TIME_US = 8000,
  parameter int             SEC_TIME_US  = 60,
  parameter logic [7:0]     MAKER_CODE   = 8'h5a,  // Arbitrary value
  parameter logic [7:0]     DEVICE_CODE  = 8'h13,  // Arbitrary value
  parameter logic [7:0]     TYPE_CODE    = 8'h40,  // Arbitrary value
  parameter logic [7:0]     CAP_CODE     = 8'h14,  // Arbitrary value
  parameter logic [127:0]   UNIQUE_CODE  = 128'h0123456789abcdef_fedcba9876543210 // Arbitrary
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic       i_si,
  input  wire logic [4:0] i_block_protect_bits,
  input  wire logic       i_protect_complement,
  input  wire logic [1:0] i_security_lock_bits,
  output var  logic       o_so,
  output var  logic       o_so_oe,
  output var  logic       o_write_in_progress,
  output var  logic       o_write_enable_latch,
  output var  logic       o_erase_start,
  output var  logic [1:0] o_erase_kind,
  output var  logic [23:0] o_erase_addr
);
  localparam int BE32_CYCLES = BE32_TIME_US * CLK_MHZ;
  localparam int BE64_CYCLES = BE64_TIME_US * CLK_MHZ;
  localparam int CHIP_CYCLES = CHIP_TIME_US * CLK_MHZ;
  localparam int SEC_CYCLES  = SEC_TIME_US * CLK_MHZ;

  logic [2:0] meta_reg, sync_reg, prev_reg;
  logic       cs_rise, cs_fall, sclk_rise, sclk_fall, si_s, cs_low;

  // Two-stage synchronisers; the second stage and a third edge-detect stage feed logic
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= 3'h4;
      sync_reg <= 3'h4;
      prev_reg <= 3'h4;
    end else begin
      meta_reg <= {i_cs_n, i_sclk, i_si};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign cs_low    = !sync_reg[SYNC_IDX_CS];
  assign cs_rise   = sync_reg[SYNC_IDX_CS] && !prev_reg[SYNC_IDX_CS];
  assign cs_fall   = !sync_reg[SYNC_IDX_CS] && prev_reg[SYNC_IDX_CS];
  assign sclk_rise = sync_reg[SYNC_IDX_SCLK] && !prev_reg[SYNC_IDX_SCLK];
  assign sclk_fall = !sync_reg[SYNC_IDX_SCLK] && prev_reg[SYNC_IDX_SCLK];
  assign si_s      = sync_reg[SYNC_IDX_SI];

  sfe_state_t   st_reg, st_next;
  logic [7:0]   cnt_reg, cnt_next;
  logic [31:0]  shin_reg, shin_next;
  logic [7:0]   op_reg, op_next;
  logic [127:0] out_reg, out_next;
  logic         so_reg, so_next, oe_reg, oe_next;
  logic         wel_reg, wel_next, wip_reg, wip_next;
  logic         start_reg, start_next;
  logic [1:0]   kind_reg, kind_next;
  logic [23:0]  addr_reg, addr_next;
  logic         tmr_done;
  logic [31:0]  word_in;
  logic [5:0]   prot_cnt;
  logic         blk_prot, chip_ok, sec_ok;

  assign word_in = {shin_reg[30:0], si_s};

  // Top-aligned protected area, growing with the low protect bits
  always_comb begin
    prot_cnt = (i_block_protect_bits[2:0] == 3'h0) ? 6'h0 :
               (i_block_protect_bits[2:0] >= 3'h5) ? BLOCK_COUNT :
               6'(6'h1 << (i_block_protect_bits[2:0] - 3'h1));
    blk_prot = ((6'({2'h0, shin_reg[19:16]}) + prot_cnt) >= BLOCK_COUNT)
               ^ i_protect_complement;
    chip_ok  = (i_block_protect_bits[2:0] == 3'h0 && !i_protect_complement) ||
               (i_block_protect_bits[2:0] == 3'h7 && i_protect_complement);
    sec_ok   = shin_reg[23:16] == 8'h00 && shin_reg[15:13] == 3'h0 &&
               shin_reg[11:10] == 2'h0 && !(|i_security_lock_bits);
  end

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    shin_next  = shin_reg;
    op_next    = op_reg;
    out_next   = out_reg;
    so_next    = so_reg;
    oe_next    = oe_reg;
    wel_next   = wel_reg;
    wip_next   = wip_reg;
    start_next = 1'b0;
    kind_next  = kind_reg;
    addr_next  = addr_reg;
    if (tmr_done) begin
      wip_next = 1'b0;
    end
    if (cs_fall) begin
      st_next  = S_IN;
      cnt_next = 8'h0;
      op_next  = OP_NONE;
    end else if (cs_rise) begin
      st_next = S_IDLE;
      oe_next = 1'b0;
      so_next = 1'b0;
      // Exact bit count at deselect and no cycle running; erases also need the latch set
      if (st_reg == S_IN && !wip_reg) begin
        unique case (op_reg)
          OP_WRITE_ENABLE_COMMAND: begin
            if (cnt_reg == CNT_OPCODE) begin
              wel_next = 1'b1;
            end
          end
          OP_BE32: begin
            if (cnt_reg == CNT_ADDR && wel_reg && !blk_prot) begin
              start_next = 1'b1;
              kind_next  = KIND_BE32;
              addr_next  = shin_reg[23:0] & MASK_BE32;
            end
          end
          OP_BE64: begin
            if (cnt_reg == CNT_ADDR && wel_reg && !blk_prot) begin
              start_next = 1'b1;
              kind_next  = KIND_BE64;
              addr_next  = shin_reg[23:0] & MASK_BE64;
            end
          end
          OP_CE_A, OP_CE_B: begin
            if (cnt_reg == CNT_OPCODE && wel_reg && chip_ok) begin
              start_next = 1'b1;
              kind_next  = KIND_CHIP;
              addr_next  = 24'h0;
            end
          end
          OP_SEC_ERASE: begin
            if (cnt_reg == CNT_ADDR && wel_reg && sec_ok) begin
              start_next = 1'b1;
              kind_next  = KIND_SEC;
              addr_next  = shin_reg[23:0] & MASK_SEC;
            end
          end
          default: ;
        endcase
        if (start_next) begin
          wip_next = 1'b1;
          wel_next = 1'b0;
        end
      end
    end else if (sclk_rise && cs_low && st_reg != S_DROP) begin
      shin_next = word_in;
      cnt_next  = (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 8'h1;
      if (st_reg == S_IN && cnt_reg == CNT_OPCODE - 8'h1) begin
        op_next = word_in[7:0];
        if (wip_reg && word_in[7:0] == OP_TYPE_CAP) begin
          st_next = S_DROP;
        end else if (word_in[7:0] == OP_TYPE_CAP) begin
          st_next  = S_OUT;
          out_next = {MAKER_CODE, TYPE_CODE, CAP_CODE, 104'h0};
        end
      end else if (st_reg == S_IN && cnt_reg == CNT_ADDR - 8'h1 &&
                   op_reg == OP_MAKER_DEV && !wip_reg) begin
        st_next  = S_OUT;
        out_next = {MAKER_CODE, DEVICE_CODE, 112'h0};
      end else if (st_reg == S_IN && cnt_reg == CNT_DUMMY - 8'h1 &&
                   op_reg == OP_UNIQUE && !wip_reg) begin
        st_next  = S_OUT;
        out_next = UNIQUE_CODE;
      end
    end else if (sclk_fall && st_reg == S_OUT) begin
      so_next  = out_reg[127];
      oe_next  = 1'b1;
      out_next = {out_reg[126:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg    <= S_IDLE;
      cnt_reg   <= 8'h0;
      shin_reg  <= 32'h0;
      op_reg    <= OP_NONE;
      out_reg   <= 128'h0;
      so_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      wel_reg   <= 1'b0;
      wip_reg   <= 1'b0;
      start_reg <= 1'b0;
      kind_reg  <= KIND_BE32;
      addr_reg  <= 24'h0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      shin_reg  <= shin_next;
      op_reg    <= op_next;
      out_reg   <= out_next;
      so_reg    <= so_next;
      oe_reg    <= oe_next;
      wel_reg   <= wel_next;
      wip_reg   <= wip_next;
      start_reg <= start_next;
      kind_reg  <= kind_next;
      addr_reg  <= addr_next;
    end
  end

  sfe_erase_timer #(
    .BE32_CYCLES (BE32_CYCLES),
    .BE64_CYCLES (BE64_CYCLES),
    .CHIP_CYCLES (CHIP_CYCLES),
    .SEC_CYCLES  (SEC_CYCLES)
  ) u_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (start_reg),
    .i_kind  (kind_reg),
    .o_done  (tmr_done)
  );

  // Status bits are live flops, readable at any time
  assign o_so                 = so_reg;
  assign o_so_oe              = oe_reg;
  assign o_write_in_progress  = wip_reg;
  assign o_write_enable_latch = wel_reg;
  assign o_erase_start        = start_reg;
  assign o_erase_kind         = kind_reg;
  assign o_erase_addr         = addr_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_launch;
    start_reg ##0 wip_reg ##0 !wel_reg;
  endsequence

  a_launch_sets_busy: assert property (start_reg |-> s_launch)
    else $error("Erase start without busy flag or with latch still set");
  a_latch_required: assert property (start_reg |-> $past(wel_reg))
    else $error("Erase started without write enable latch");
  a_busy_holds: assert property (wip_reg && !tmr_done && !start_reg |=> wip_reg)
    else $error("Busy flag fell before the cycle ended");
  a_busy_clears: assert property (tmr_done |=> !wip_reg)
    else $error("Busy flag stayed high after completion");
  a_bad_count_drop: assert property (cs_rise && cnt_reg != CNT_ADDR &&
    (op_reg == OP_BE32 || op_reg == OP_BE64 || op_reg == OP_SEC_ERASE) |=> !start_reg)
    else $error("Address erase started at wrong bit count");
  a_chip_count: assert property (cs_rise && cnt_reg != CNT_OPCODE &&
    (op_reg == OP_CE_A || op_reg == OP_CE_B) |=> !start_reg)
    else $error("Chip erase started at wrong bit count");
  a_chip_protect: assert property (start_reg && kind_reg == KIND_CHIP |-> $past(chip_ok))
    else $error("Chip erase started under protection");
  a_block_protect: assert property (start_reg && kind_reg != KIND_CHIP &&
    kind_reg != KIND_SEC |-> !$past(blk_prot))
    else $error("Protected block erase started");
  a_lock_ignores: assert property (start_reg && kind_reg == KIND_SEC |->
    $past(i_security_lock_bits) == 2'h0)
    else $error("Locked security register erase started");
  a_busy_id_drop: assert property (st_reg == S_IN && wip_reg && sclk_rise && cs_low &&
    cnt_reg == 8'h7 && word_in[7:0] == OP_TYPE_CAP |=> st_reg == S_DROP)
    else $error("Identification decoded while busy");
  a_deselect_ends: assert property (cs_rise |=> st_reg == S_IDLE && !o_so_oe)
    else $error("Output still driven after deselect");
  a_out_on_fall: assert property (o_so_oe && $changed(so_reg) |-> $past(sclk_fall))
    else $error("Output changed away from a falling clock edge");
  a_id_busy_quiet: assert property (wip_reg && st_reg != S_OUT |=> st_reg != S_OUT)
    else $error("Identification output started during a cycle");
  a_block_aligned: assert property (start_reg && (kind_reg == KIND_BE32 ||
    kind_reg == KIND_BE64) |-> (kind_reg == KIND_BE64) ? addr_reg[15:0] == 16'h0 :
    addr_reg[14:0] == 15'h0) else $error("Block erase address not aligned");
  a_write_enable_command_latch: assert property (cs_rise && st_reg == S_IN && !wip_reg &&
    op_reg == OP_WRITE_ENABLE_COMMAND && cnt_reg == CNT_OPCODE |=> wel_reg)
    else $error("Write enable command did not set the latch");
endmodule : sfe_flash_cmds
`default_nettype wire

// ==== inc/sfe_pkg.sv ====
`default_nettype none
package sfe_pkg;
  localparam int          CLK_MHZ       = 50;
  localparam logic [7:0]  OP_WRITE_ENABLE_COMMAND       = 8'h06;
  localparam logic [7:0]  OP_BE32       = 8'h52;
  localparam logic [7:0]  OP_BE64       = 8'hd8;
  localparam logic [7:0]  OP_CE_A       = 8'h60;
  localparam logic [7:0]  OP_CE_B       = 8'hc7;
  localparam logic [7:0]  OP_MAKER_DEV  = 8'h90;
  localparam logic [7:0]  OP_TYPE_CAP   = 8'h9f;
  localparam logic [7:0]  OP_UNIQUE     = 8'h4b;
  localparam logic [7:0]  OP_SEC_ERASE  = 8'h44;
  localparam logic [7:0]  OP_NONE       = 8'h00;
  localparam logic [7:0]  CNT_OPCODE    = 8'h08;
  localparam logic [7:0]  CNT_ADDR      = 8'h20;
  localparam logic [7:0]  CNT_DUMMY     = 8'h28;
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [1:0]  KIND_BE32     = 2'h0;
  localparam logic [1:0]  KIND_BE64     = 2'h1;
  localparam logic [1:0]  KIND_CHIP     = 2'h2;
  localparam logic [1:0]  KIND_SEC      = 2'h3;
  localparam logic [23:0] MASK_BE32     = 24'hff8000;
  localparam logic [23:0] MASK_BE64     = 24'hff0000;
  localparam logic [23:0] MASK_SEC      = 24'h001000;
  localparam logic [5:0]  BLOCK_COUNT   = 6'h10;
  localparam int          SYNC_IDX_CS   = 2;
  localparam int          SYNC_IDX_SCLK = 1;
  localparam int          SYNC_IDX_SI   = 0;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_IN   = 4'b0010,
    S_OUT  = 4'b0100,
    S_DROP = 4'b1000
  } sfe_state_t;
endpackage : sfe_pkg
`default_nettype wire

// ==== verilog/sfe_erase_timer.sv ====
`default_nettype none
module sfe_erase_timer
  import sfe_pkg::*;
#(
  parameter int BE32_CYCLES = 1,
  parameter int BE64_CYCLES = 1,
  parameter int CHIP_CYCLES = 1,
  parameter int SEC_CYCLES  = 1
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [1:0] i_kind,
  output var  logic       o_done
);
  logic [31:0] cnt_reg, cnt_next;
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;
  logic [31:0] load;

  // Each erase kind has its own duration
  always_comb begin
    unique case (i_kind)
      KIND_BE32: load = 32'(BE32_CYCLES);
      KIND_BE64: load = 32'(BE64_CYCLES);
      KIND_CHIP: load = 32'(CHIP_CYCLES);
      KIND_SEC:  load = 32'(SEC_CYCLES);
    endcase
  end

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (i_start) begin
      busy_next = 1'b1;
      cnt_next  = (load > 32'h1) ? load - 32'h1 : 32'h0;
    end else if (busy_reg) begin
      if (cnt_reg == 32'h0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;

  a_done_after_start: assert property (@(posedge i_clk) disable iff (i_reset)
    i_start |=> !done_reg) else $error("Timer finished in the start cycle");
endmodule : sfe_erase_timer
`default_nettype wire

// ==== bench/sfe_host_model.sv ====
`default_nettype none
module sfe_host_model (
  output var  logic o_cs_n,
  output var  logic o_sclk,
  output var  logic o_si,
  input  wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end
  // Never enters deep power-down, so 9FH is ignored only while a cycle runs
  // Clock parks low between frames; data wanders once released
  task automatic xfer(input logic [47:0] tx, input int ntx, input int nrx,
                      output logic [127:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx)
        o_si = tx[ntx-1-i];
      else
        o_si = ~o_si;
      #(HALF) o_sclk = 1'b1;
      // Late sample: output settles after the synchroniser delay
      #(HALF-1) rx = (i < ntx) ? rx : {rx[126:0], i_so};
      #1 o_sclk = 1'b0;
    end
    #(HALF) o_cs_n = 1'b1;
    #(HALF) o_si = ~o_si;
    #(4*HALF);
  endtask : xfer
endmodule : sfe_host_model
`default_nettype wire

// ==== bench/serial_flash_erase_id_cmds_tb.sv ====
`default_nettype none
module serial_flash_erase_id_cmds_tb
  import sfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]   MK = 8'ha5;  // Arbitrary
  localparam logic [7:0]   DV = 8'h3c;  // Arbitrary
  localparam logic [7:0]   TY = 8'h71;  // Arbitrary
  localparam logic [7:0]   CP = 8'h0e;  // Arbitrary
  localparam logic [127:0] UQ = 128'h0f1e2d3c4b5a6978_8796a5b4c3d2e1f0;  // Arbitrary
  localparam logic [5:0]   CT [6] = '{6'h20, 6'h21, 6'h3e, 6'h05, 6'h1c, 6'h03};
  localparam logic [23:0]  SA [5] = '{24'h000000, 24'h001000, 24'h000400, 24'h010000,
                                      24'h002000};
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [4:0]  bp = 5'h00;
  logic        cmp = 1'b0;
  logic [1:0]  lock = 2'h0;
  wire logic   cs_n;
  wire logic   sclk;
  wire logic   si;
  logic        so;
  wire logic   so_pin;
  logic        so_oe;
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        est;
  logic [1:0]  ekind;
  logic [23:0] eaddr;
  logic [25:0] exp_q[$];
  logic        oe_seen = 1'b0;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  sfe_flash_cmds #(.BE32_TIME_US(1), .BE64_TIME_US(20), .CHIP_TIME_US(1), .SEC_TIME_US(1),
    .MAKER_CODE(MK), .DEVICE_CODE(DV), .TYPE_CODE(TY), .CAP_CODE(CP), .UNIQUE_CODE(UQ)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si),
    .i_block_protect_bits(bp), .i_protect_complement(cmp), .i_security_lock_bits(lock),
    .o_so(so), .o_so_oe(so_oe), .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch),
    .o_erase_start(est), .o_erase_kind(ekind), .o_erase_addr(eaddr));
  // Pull-up on the released data line, so an undriven bit reads as one
  assign so_pin = so_oe ? so : 1'b1;
  sfe_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_si(si), .i_so(so_pin));

  always #10 i_clk = ~i_clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [127:0] e, input logic [127:0] got);
    checks_done++;
    if (got !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic prot(input logic [4:0] b, input logic c, input logic [1:0] l);
    @(posedge i_clk);
    #2;
    bp = b;
    cmp = c;
    lock = l;
  endtask : prot

  task automatic erase(input logic [1:0] k, input logic [7:0] op, input logic [23:0] a,
                       input int n, input bit wr, input bit ok, input bit probe);
    logic [47:0]  tx;
    logic [127:0] r;
    int           len;
    len = (k == KIND_CHIP) ? 8 : 32;
    tx = (k == KIND_CHIP) ? {40'h0, op} : {16'h0, op, a};
    tx = (n > len) ? tx << (n - len) : tx >> (len - n);
    if (wr) begin
      host.xfer({40'h0, OP_WRITE_ENABLE_COMMAND}, 8, 0, r);
      chk("latch set", 1, write_enable_latch);
    end
    if (ok)
      exp_q.push_back({k, a & ((k == KIND_BE32) ? MASK_BE32 :
                               (k == KIND_BE64) ? MASK_BE64 : MASK_SEC)});
    host.xfer(tx, n, 0, r);
    chk("busy after cmd", ok, write_in_progress);
    if (probe) begin
      oe_seen = 1'b0;
      host.xfer({40'h0, OP_TYPE_CAP}, 8, 24, r);
      chk("id while busy", {104'h0, 24'hffffff}, r);
      host.xfer({16'h0, OP_MAKER_DEV, 24'h000000}, 32, 16, r);
      chk("maker while busy", {112'h0, 16'hffff}, r);
      chk("oe while busy", 0, oe_seen);
      chk("busy kept", 1, write_in_progress);
    end
    for (int i = 0; i < 1500 && write_in_progress !== 1'b0; i++)
      @(posedge i_clk);
    chk("busy over", 0, write_in_progress);
  endtask : erase

  task automatic rd(input logic [47:0] tx, input int ntx, input int nrx, input logic [127:0] e);
    logic [127:0] r;
    host.xfer(tx, ntx, nrx, r);
    chk("id bits", e, r);
    chk("oe after end", 0, so_oe);
  endtask : rd

  always @(posedge i_clk) begin
    logic [25:0] e;
    cycles <= cycles + 1;
    if (so_oe === 1'b1)
      oe_seen <= 1'b1;
    if (est === 1'b1) begin
      chk("start wanted", 1, exp_q.size() != 0);
      if (exp_q.size() != 0)
        e = exp_q.pop_front();
      else
        e = '1;
      chk("erase kind", e[25:24], ekind);
      if (e[25:24] != KIND_CHIP)
        chk("erase addr", e[23:0], eaddr);
      chk("busy at start", 1, write_in_progress);
      chk("latch at start", 0, write_enable_latch);
    end
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(55));
    repeat (20) @(posedge i_clk);
    #2 i_reset = 1'b0;
    repeat (5) @(posedge i_clk);
    for (int j = 0; j < 3; j++) begin
      prot({2'($urandom), 3'h0}, 1'b0, 2'h0);
      erase(KIND_BE32, OP_BE32, 24'($urandom) & 24'h0fffff, 32, 1, 1, 0);
      erase(KIND_BE64, OP_BE64, 24'($urandom) & 24'h0fffff, 32, 1, 1, 0);
    end
    erase(KIND_BE32, OP_BE32, 24'h012345, 32, 0, 0, 0);
    erase(KIND_BE32, OP_BE32, 24'h012345, 31, 1, 0, 0);
    erase(KIND_BE64, OP_BE64, 24'h012345, 33, 1, 0, 0);
    prot(5'h01, 1'b0, 2'h0);
    erase(KIND_BE64, OP_BE64, 24'h0f0000 | 24'($urandom_range(0, 65535)), 32, 1, 0, 0);
    erase(KIND_BE32, OP_BE32, 24'h0e8000, 32, 1, 1, 0);
    for (int i = 0; i < 6; i++) begin
      prot({2'($urandom), CT[i][4:2]}, CT[i][1], 2'h0);
      erase(KIND_CHIP, CT[i][0] ? OP_CE_B : OP_CE_A, 24'h0, 8, 1, CT[i][5], 0);
    end
    prot(5'h00, 1'b0, 2'h0);
    erase(KIND_CHIP, OP_CE_B, 24'h0, 9, 1, 0, 0);
    erase(KIND_CHIP, OP_CE_A, 24'h0, 7, 1, 0, 0);
    for (int i = 0; i < 5; i++)
      erase(KIND_SEC, OP_SEC_ERASE, SA[i] | 24'($urandom_range(0, 1023)), 32, 1, i < 2, 0);
    prot(5'h00, 1'b0, 2'($urandom_range(1, 3)));
    erase(KIND_SEC, OP_SEC_ERASE, 24'h001000, 32, 1, 0, 0);
    prot(5'h00, 1'b0, 2'h0);
    erase(KIND_BE64, OP_BE64, 24'h020000, 32, 1, 1, 1);
    rd({40'h0, OP_TYPE_CAP}, 8, 32, {96'h0, MK, TY, CP, 8'h00});
    rd({16'h0, OP_MAKER_DEV, 24'h000000}, 32, 16, {112'h0, MK, DV});
    rd({8'h0, OP_UNIQUE, 32'h0}, 40, 128, UQ);
    rd({40'h0, OP_TYPE_CAP}, 8, 5, {123'h0, MK[7:3]});
    chk("queue left", 0, exp_q.size());
    report_and_stop();
  end
endmodule : serial_flash_erase_id_cmds_tb
`default_nettype wire
